/* File: otps_sequencer.sv */
`timescale 1ns/1ps
`include "otps_defines.svh"

// What this block does
// - Each transfer moves one eight-bit byte on the data lines.
// - Address and data stand stable before the write strobe falls.
// - Every write strobe pulse is active low, high-low-high.
// - Whole array or single bytes may be programmed in any order.
// - Long-pulse mode verifies the byte after every prime pulse.
// - Long-pulse mode retries 1 ms prime pulses, at most 25 per byte.
// - After pass at X prime pulses, apply one final pulse of 3X.
// - Short-pulse mode verifies after each 100 us pulse; fails after ten.
// - A read command reads back one byte and checks it against cmdData.
module otps_sequencer
    import otps_pkg::*;
#(
    parameter int ADDR_W = `OTPS_ADDR_W,
    parameter int DATA_W = `OTPS_DATA_W,
    parameter int PRIME_CYC = `OTPS_PRIME_CYC,
    parameter int SHORT_CYC = `OTPS_SHORT_CYC,
    parameter int SETUP_CYC = `OTPS_SETUP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command
    input wire logic cmdProgram,
    input wire logic cmdRead,
    input wire logic shortMode,
    input wire logic [ADDR_W-1:0] cmdAddress,
    input wire logic [DATA_W-1:0] cmdData,
    output logic cmdReady,
    // Result
    output otps_result_s result,
    output logic [4:0] pulseCount,
    // Device pins
    output otps_pins_s pins,
    input wire logic [DATA_W-1:0] programmer_data_lines_in,
    output logic [DATA_W-1:0] programmer_data_lines_out,
    output logic programmer_data_lines_oe_n
);
    localparam int CNT_W = 24;
    localparam logic [4:0] FAST_MAX = 5'(`OTPS_FAST_MAX_PULSES);
    localparam logic [4:0] SHORT_MAX = 5'(`OTPS_SHORT_MAX_PULSES);

    otps_state_e state;
    otps_state_e next_state;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] wantData;
    logic isShort;
    logic [DATA_W-1:0] dataSync1;
    logic [DATA_W-1:0] dataSync2;
    logic timerStart;
    logic [CNT_W-1:0] timerLength;
    logic timerBusy;
    logic timerExpired;
    logic match;
    logic finalPending;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataSync1 <= '0;
            dataSync2 <= '0;
        end else begin
            dataSync1 <= programmer_data_lines_in;
            dataSync2 <= dataSync1;
        end
    end

    function automatic logic [CNT_W-1:0] pulseLen(input logic shortSel, input logic [4:0] n, input logic fin);
        logic [CNT_W-1:0] unit;
        unit = shortSel ? CNT_W'(SHORT_CYC) : CNT_W'(PRIME_CYC);
        pulseLen = fin ? CNT_W'(unit * n * `OTPS_FINAL_FACTOR) : unit;
    endfunction

    assign match = (dataSync2 == wantData);

    // ------------------------------------------------------------
    // Pulse timer
    // ------------------------------------------------------------
    otps_timer #(.CNT_W(CNT_W)) uTimer (
        .clk(clk),
        .reset_n(reset_n),
        .start(timerStart),
        .length(timerLength),
        .busy(timerBusy),
        .expired(timerExpired)
    );

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        timerStart = 1'b0;
        timerLength = CNT_W'(SETUP_CYC);
        case (state)
            OTPS_IDLE: begin
                if (cmdProgram || cmdRead) begin
                    timerStart = 1'b1;
                    next_state = cmdProgram ? OTPS_SETUP : OTPS_RSET;
                end
            end
            OTPS_SETUP: begin
                if (timerExpired) begin
                    timerStart = 1'b1;
                    timerLength = pulseLen(isShort, pulseCount, finalPending);
                    next_state = finalPending ? OTPS_FINAL : OTPS_PULSE;
                end
            end
            OTPS_PULSE: begin
                if (timerExpired) begin
                    timerStart = 1'b1;
                    next_state = OTPS_VSET;
                end
            end
            OTPS_VSET: begin
                if (timerExpired) begin
                    next_state = OTPS_VSAMP;
                end
            end
            OTPS_VSAMP: begin
                if (match && isShort) begin
                    next_state = OTPS_DONE;
                end else if (!match && pulseCount >= (isShort ? SHORT_MAX : FAST_MAX)) begin
                    next_state = OTPS_DONE;
                end else begin
                    // Every pulse, final included, gets a fresh data setup
                    timerStart = 1'b1;
                    next_state = OTPS_SETUP;
                end
            end
            OTPS_FINAL: begin
                if (timerExpired) begin
                    next_state = OTPS_DONE;
                end
            end
            OTPS_RSET: begin
                if (timerExpired) begin
                    next_state = OTPS_RSAMP;
                end
            end
            OTPS_RSAMP: next_state = OTPS_DONE;
            OTPS_DONE: next_state = OTPS_IDLE;
            default: next_state = OTPS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= OTPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign cmdReady = (state == OTPS_IDLE);

    // ------------------------------------------------------------
    // Command capture and pulse counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            address <= '0;
            wantData <= `OTPS_ERASED_BYTE;
            isShort <= 1'b0;
        end else if (state == OTPS_IDLE && (cmdProgram || cmdRead)) begin
            address <= cmdAddress;
            wantData <= cmdData;
            isShort <= shortMode;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            finalPending <= 1'b0;
        end else if (state == OTPS_VSAMP || state == OTPS_FINAL) begin
            finalPending <= (state == OTPS_VSAMP) && match && !isShort;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCount <= '0;
        end else if (state == OTPS_IDLE && cmdProgram) begin
            pulseCount <= 5'h00;
        end else if (state != OTPS_PULSE && next_state == OTPS_PULSE) begin
            pulseCount <= pulseCount + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= '0;
        end else if (state == OTPS_IDLE && (cmdProgram || cmdRead)) begin
            result <= '0;
        end else if (state == OTPS_VSAMP) begin
            result.readData <= dataSync2;
            result.readMatch <= match;
            result.fail <= !match && pulseCount >= (isShort ? SHORT_MAX : FAST_MAX);
            result.done <= (match && isShort) || (!match && pulseCount >= (isShort ? SHORT_MAX : FAST_MAX));
        end else if (state == OTPS_FINAL && timerExpired) begin
            result.done <= 1'b1;
        end else if (state == OTPS_RSAMP) begin
            result.readData <= dataSync2;
            result.readMatch <= match;
            result.done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins <= {1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}};
            programmer_data_lines_out <= '0;
            programmer_data_lines_oe_n <= 1'b1;
        end else begin
            pins.byteAddressLines <= address;
            programmer_data_lines_out <= wantData;
            case (next_state)
                OTPS_SETUP, OTPS_PULSE, OTPS_FINAL: begin
                    pins.chipSelect_n <= 1'b0;
                    pins.outputSelect_n <= 1'b1;
                    pins.writeStrobe_n <= !(next_state != OTPS_SETUP);
                    programmer_data_lines_oe_n <= 1'b0;
                end
                OTPS_VSET, OTPS_VSAMP, OTPS_RSET, OTPS_RSAMP: begin
                    pins.chipSelect_n <= 1'b0;
                    pins.outputSelect_n <= 1'b0;
                    pins.writeStrobe_n <= 1'b1;
                    programmer_data_lines_oe_n <= 1'b1;
                end
                default: begin
                    pins.chipSelect_n <= 1'b1;
                    pins.outputSelect_n <= 1'b1;
                    pins.writeStrobe_n <= 1'b1;
                    programmer_data_lines_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seqStrobeLow;
        !pins.writeStrobe_n;
    endsequence

    AST_STROBE_NEEDS_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
        seqStrobeLow |-> !pins.chipSelect_n && pins.outputSelect_n && !programmer_data_lines_oe_n)
        else $error("strobe low without select");
    AST_SETUP_BEFORE_STROBE: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(pins.writeStrobe_n) |-> $past(!programmer_data_lines_oe_n) && $stable(pins.byteAddressLines))
        else $error("strobe fell without setup");
    AST_FAST_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
        !isShort |-> pulseCount <= FAST_MAX)
        else $error("too many prime pulses");
    AST_SHORT_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
        isShort |-> pulseCount <= SHORT_MAX)
        else $error("too many short pulses");
    AST_VERIFY_AFTER_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        (state == OTPS_PULSE && timerExpired) |=> state == OTPS_VSET)
        else $error("no verify after pulse");
    AST_FAIL_AT_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
        (state == OTPS_VSAMP && !match && pulseCount == (isShort ? SHORT_MAX : FAST_MAX)) |=> result.fail)
        else $error("fail flag missing");
    AST_COUNT_CLEARED: assert property (@(posedge clk) disable iff (!reset_n)
        (state == OTPS_IDLE && cmdProgram) |=> pulseCount == 5'h00)
        else $error("counter not cleared");
    AST_PASS_TO_FINAL: assert property (@(posedge clk) disable iff (!reset_n)
        (state == OTPS_VSAMP && match && !isShort) |=> state == OTPS_SETUP && finalPending && !result.done)
        else $error("final pulse not armed");
    AST_FINAL_AFTER_PASS: assert property (@(posedge clk) disable iff (!reset_n)
        (state == OTPS_SETUP && timerExpired && finalPending) |=> state == OTPS_FINAL && !pins.writeStrobe_n)
        else $error("final pulse missing");
    AST_READ_FLOATS: assert property (@(posedge clk) disable iff (!reset_n)
        state == OTPS_RSAMP |-> programmer_data_lines_oe_n && !pins.outputSelect_n)
        else $error("host drives during read");
endmodule

/* File: otps_defines.svh */
`ifndef OTPS_DEFINES_SVH
`define OTPS_DEFINES_SVH

// Array geometry
`define OTPS_ADDR_W 13
`define OTPS_DATA_W 8
`define OTPS_ERASED_BYTE 8'hFF

// Pulse limits
`define OTPS_FAST_MAX_PULSES 25
`define OTPS_SHORT_MAX_PULSES 10
`define OTPS_FINAL_FACTOR 3

// Times in ns, and the same rounded up to clock cycles
`define OTPS_CLK_PERIOD_NS 25
`define OTPS_PRIME_NS 1000000
`define OTPS_SHORT_NS 100000
`define OTPS_SETUP_NS 2000
`define OTPS_PRIME_CYC ((`OTPS_PRIME_NS + `OTPS_CLK_PERIOD_NS - 1) / `OTPS_CLK_PERIOD_NS)
`define OTPS_SHORT_CYC ((`OTPS_SHORT_NS + `OTPS_CLK_PERIOD_NS - 1) / `OTPS_CLK_PERIOD_NS)
`define OTPS_SETUP_CYC ((`OTPS_SETUP_NS + `OTPS_CLK_PERIOD_NS - 1) / `OTPS_CLK_PERIOD_NS)

`endif

/* File: otps_pkg.sv */
package otps_pkg;
    `include "otps_defines.svh"

    typedef enum logic [8:0] {
        OTPS_IDLE = 9'h001,
        OTPS_SETUP = 9'h002,
        OTPS_PULSE = 9'h004,
        OTPS_VSET = 9'h008,
        OTPS_VSAMP = 9'h010,
        OTPS_FINAL = 9'h020,
        OTPS_RSET = 9'h040,
        OTPS_RSAMP = 9'h080,
        OTPS_DONE = 9'h100
    } otps_state_e;

    typedef struct packed {
        logic chipSelect_n;
        logic outputSelect_n;
        logic writeStrobe_n;
        logic [`OTPS_ADDR_W-1:0] byteAddressLines;
    } otps_pins_s;

    typedef struct packed {
        logic done;
        logic fail;
        logic readMatch;
        logic [`OTPS_DATA_W-1:0] readData;
    } otps_result_s;
endpackage

/* File: otps_timer.sv */
`timescale 1ns/1ps
`include "otps_defines.svh"

module otps_timer
    import otps_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] length,
    output logic busy,
    output logic expired
);
    logic [CNT_W-1:0] count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (start) begin
            count <= length;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign busy = (count != '0);
    assign expired = (count == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

/* File: otps_device_model.sv */
`timescale 1ns/1ps

module otps_device_model
    import otps_pkg::*;
#(
    parameter int PROTECT_BIT = 1
) (
    // Clock for pulse timing
    input wire logic clk,
    // Device pins
    input wire otps_pins_s pins,
    input wire logic [7:0] busIn,
    output logic [7:0] devData,
    output logic devOe,
    // Test control and status
    input wire integer needPulses,
    output int lastLen,
    output int bytePulses,
    output int holdErr
);
    logic [7:0] mem [0:8191];
    logic [12:0] pAddr;
    logic [7:0] pData;
    logic progOk;
    int lowLen;

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        lastLen = 0;
        bytePulses = 0;
        holdErr = 0;
        lowLen = 0;
        pAddr = '0;
        progOk = 1'b0;
    end

    // Drives only with select and output select low, strobe high, unprotected
    assign devOe = !pins.chipSelect_n && !pins.outputSelect_n && pins.writeStrobe_n && PROTECT_BIT != 0;
    assign devData = mem[pins.byteAddressLines];

    always @(negedge pins.writeStrobe_n) begin
        if (pins.byteAddressLines != pAddr) begin
            bytePulses = 0;
        end
        pAddr = pins.byteAddressLines;
        pData = busIn;
        progOk = !pins.chipSelect_n && pins.outputSelect_n;
        lowLen = 0;
    end

    // Pulse length and hold of address and data while strobe is low
    always @(posedge clk) begin
        if (pins.writeStrobe_n === 1'b0) begin
            lowLen++;
            if (pins.byteAddressLines !== pAddr || busIn !== pData) begin
                holdErr++;
            end
        end
    end

    // Cell accepts the byte only after enough pulses; bits only clear
    always @(posedge pins.writeStrobe_n) begin
        if (progOk) begin
            lastLen = lowLen;
            bytePulses++;
            if (bytePulses >= needPulses) begin
                mem[pAddr] = mem[pAddr] & pData;
            end
        end
    end
endmodule

/* File: test_otps_sequencer.sv */
`timescale 1ns/1ps

module test_otps_sequencer
    import otps_pkg::*;
;
    localparam int PRIME = 20;
    localparam int SHORT = 10;
    logic clk;
    logic reset_n;
    logic cmdProgram;
    logic cmdRead;
    logic shortMode;
    logic [12:0] cmdAddress;
    logic [7:0] cmdData;
    logic cmdReady;
    otps_result_s result;
    logic [4:0] pulseCount;
    otps_pins_s pins;
    logic [7:0] hostOut;
    logic hostOe_n;
    logic [7:0] devData;
    logic devOe;
    logic [7:0] busVal;
    logic [7:0] lastBus;
    int needPulses;
    int lastLen;
    int bytePulses;
    int holdErr;
    int err_count;
    int comparisons;

    // ----------------------------------------
    // Data bus: released lines show the inverse of the last value
    // ----------------------------------------
    assign busVal = !hostOe_n ? hostOut : (devOe ? devData : ~lastBus);

    otps_sequencer #(.PRIME_CYC(PRIME), .SHORT_CYC(SHORT), .SETUP_CYC(4)) dut (
        .clk(clk), .reset_n(reset_n), .cmdProgram(cmdProgram), .cmdRead(cmdRead), .shortMode(shortMode),
        .cmdAddress(cmdAddress), .cmdData(cmdData), .cmdReady(cmdReady), .result(result),
        .pulseCount(pulseCount), .pins(pins), .programmer_data_lines_in(busVal),
        .programmer_data_lines_out(hostOut), .programmer_data_lines_oe_n(hostOe_n));

    otps_device_model model (
        .clk(clk), .pins(pins), .busIn(busVal), .devData(devData), .devOe(devOe),
        .needPulses(needPulses), .lastLen(lastLen), .bytePulses(bytePulses), .holdErr(holdErr));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        lastBus <= busVal;
        if (hostOe_n === 1'b0 && devOe) begin
            err_count++;
            $display("wrong value bus owner expected one seen two");
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic runCmd(input logic prog, input logic sm, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        check("cmdReady", 1, cmdReady);
        cmdProgram = prog;
        cmdRead = !prog;
        shortMode = sm;
        cmdAddress = a;
        cmdData = d;
        @(negedge clk);
        cmdProgram = 1'b0;
        cmdRead = 1'b0;
        while (result.done !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check("done", 1, result.done);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        check("cmdReady", 1, cmdReady);
        check("selects", 3'b111, {pins.chipSelect_n, pins.outputSelect_n, pins.writeStrobe_n});
        check("oe_n", 1, hostOe_n);
        check("result", 0, result);
        $display("test reset done");
    endtask

    task automatic test_fast_pair;
        needPulses = 3;
        runCmd(1'b1, 1'b0, 13'h0000, 8'h5A);
        check("fail", 0, result.fail);
        check("pulses", 4, bytePulses);
        check("final length", 3 * 3 * PRIME, lastLen);
        needPulses = 1;
        runCmd(1'b1, 1'b0, 13'h0001, 8'hC3);
        check("pulses", 2, bytePulses);
        check("final length", 3 * PRIME, lastLen);
        check("hold", 0, holdErr);
        $display("test fast_pair done");
    endtask

    task automatic test_short;
        needPulses = 2;
        runCmd(1'b1, 1'b1, 13'h1FFF, 8'h00);
        check("fail", 0, result.fail);
        check("pulseCount", 2, pulseCount);
        check("pulses", 2, bytePulses);
        check("pulse length", SHORT, lastLen);
        $display("test short done");
    endtask

    task automatic test_limits;
        for (int m = 0; m < 2; m++) begin
            needPulses = 1000;
            runCmd(1'b1, m[0], 13'h0100 + 13'(m), 8'h00);
            check("fail", 1, result.fail);
            check("pulseCount", (m != 0) ? 10 : 25, pulseCount);
            check("pulse length", (m != 0) ? SHORT : PRIME, lastLen);
        end
        check("hold", 0, holdErr);
        $display("test limits done");
    endtask

    task automatic test_one_pass;
        needPulses = 1;
        runCmd(1'b1, 1'b0, 13'h0002, 8'hF0);
        check("fail", 0, result.fail);
        runCmd(1'b1, 1'b1, 13'h0002, 8'h0F);
        check("fail", 1, result.fail);
        $display("test one_pass done");
    endtask

    task automatic test_read;
        logic [12:0] addrs [6] = '{13'h0000, 13'h0001, 13'h1FFF, 13'h0ABC, 13'h0100, 13'h0002};
        logic [7:0] vals [6] = '{8'h5A, 8'hC3, 8'h00, 8'hFF, 8'hFF, 8'h00};
        foreach (addrs[i]) begin
            runCmd(1'b0, 1'b0, addrs[i], vals[i]);
            check("readData", vals[i], result.readData);
            check("readMatch", 1, result.readMatch);
        end
        runCmd(1'b0, 1'b0, 13'h0ABC, 8'h12);
        check("readMatch", 0, result.readMatch);
        check("readData", 8'hFF, result.readData);
        $display("test read done");
    endtask

    initial begin
        #(60000 * 25);
        err_count++;
        $display("watchdog expired");
        final_report;
    end

    initial begin
        reset_n = 1'b0;
        cmdProgram = 1'b0;
        cmdRead = 1'b0;
        shortMode = 1'b0;
        cmdAddress = '0;
        cmdData = '0;
        needPulses = 1;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(negedge clk);
        test_reset;
        reset_n = 1'b1;
        test_fast_pair;
        test_short;
        test_limits;
        test_one_pass;
        test_read;
        final_report;
    end
endmodule
